// ===== shared/sesf_pkg.sv
/*
 * Constants and types of the serial memory slave front end.
 * Assumes a 250 MHz core clock; all times convert to cycles here.
 */
package sesf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // noise suppression, least time rounds up
    localparam int unsigned GLITCH_FILTER_TIME_NS = 250;
    localparam int unsigned GLITCH_CYC =
        (GLITCH_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // transmit hold past a falling clock, least time rounds up
    localparam int unsigned SDA_HOLD_TIME_NS = 300;
    localparam int unsigned SDA_HOLD_CYC =
        (SDA_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // program_cycle_time per word
    localparam int unsigned PROG_CYCLE_MIN_MS = 20;
    localparam int unsigned PROG_CYCLE_MAX_MS = 100;
    localparam int unsigned PROG_MIN_CYC =
        (PROG_CYCLE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROG_MAX_CYC = PROG_CYCLE_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned PROG_CNT_W = 27;
    localparam int unsigned FILT_CNT_W = 8;
    // fixed upper four bits of the slave address
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam int unsigned MEM_WORDS = 256;
    localparam logic [1:0] MAX_WRITE_BYTES = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE   = 3'h0,
        S_ADDR   = 3'h1,
        S_WORD   = 3'h3,
        S_WDATA  = 3'h2,
        S_RDATA  = 3'h6,
        S_IGNORE = 3'h4
    } sesf_state_t;

    typedef enum logic {
        P_IDLE = 1'b0,
        P_RUN  = 1'b1
    } sesf_prog_state_t;
endpackage

// ===== shared/sesf_if.sv
/*
 * Carriers between the front end and its filter and programming units.
 * Assumes all three modules share core_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
interface sesf_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic idle;
    logic [2:0] cs;
    modport src (output scl, sda, scl_rise, scl_fall, start, stop, idle, cs);
    modport dst (input scl, sda, scl_rise, scl_fall, start, stop, idle, cs);
endinterface

interface sesf_prog_if;
    logic push_valid;
    logic push_ready;
    logic [7:0] push_addr;
    logic [7:0] push_data;
    logic commit;
    logic busy;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    modport ctl (output push_valid, push_addr, push_data, commit,
                 input push_ready, busy, wr_en, wr_addr, wr_data);
    modport prg (input push_valid, push_addr, push_data, commit,
                 output push_ready, busy, wr_en, wr_addr, wr_data);
endinterface
`default_nettype wire

// ===== verilog/sesf_filter.sv
/*
 * Pin synchronisers, noise filters and bus condition detection.
 * Assumes raw pins from outside the clock domain; idle bus is high.
 */
`timescale 1ns/10ps
`default_nettype none
module sesf_filter #(
    parameter int unsigned FILT_CYC = sesf_pkg::GLITCH_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] cs_i,
    sesf_line_if.src line
);
    logic [1:0] raw_in;
    logic [1:0] filt;
    logic [1:0] prev;
    logic [2:0] cs_meta;
    logic [2:0] cs_syn;

    assign raw_in = {scl_i, sda_i};

    for (genvar i = 0; i < 2; i++) begin : g_flt
        logic meta;
        logic syn;
        logic f;
        logic [sesf_pkg::FILT_CNT_W-1:0] fcnt;
        logic next_f;
        logic [sesf_pkg::FILT_CNT_W-1:0] next_fcnt;
        // level must persist before it is believed
        always_comb begin
            next_f = f;
            next_fcnt = '0;
            if (syn != f) begin
                if (fcnt >= sesf_pkg::FILT_CNT_W'(FILT_CYC - 1)) begin
                    next_f = syn;
                end else begin
                    next_fcnt = fcnt + 1'b1;
                end
            end
        end
        always_ff @(posedge core_clk_i) begin
            if (srst_i) begin
                meta <= 1'b1;
                syn <= 1'b1;
                f <= 1'b1;
                fcnt <= '0;
            end else begin
                meta <= raw_in[i];
                syn <= meta;
                f <= next_f;
                fcnt <= next_fcnt;
            end
        end
        assign filt[i] = f;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prev <= 2'h3;
            cs_meta <= 3'h0;
            cs_syn <= 3'h0;
        end else begin
            prev <= filt;
            cs_meta <= cs_i;
            cs_syn <= cs_meta;
        end
    end

    assign line.scl = filt[1];
    assign line.sda = filt[0];
    assign line.scl_rise = filt[1] & ~prev[1];
    assign line.scl_fall = ~filt[1] & prev[1];
    // data edge while clock high is a condition, not data
    assign line.start = filt[1] & prev[1] & prev[0] & ~filt[0];
    assign line.stop = filt[1] & prev[1] & ~prev[0] & filt[0];
    assign line.idle = filt[1] & filt[0];
    assign line.cs = cs_syn;
endmodule
`default_nettype wire

// ===== verilog/sesf_prog.sv
/*
 * Two-entry write buffer and timed erase/write cycle.
 * Assumes commit arrives only after a stop; drains one word per cycle time.
 */
`timescale 1ns/10ps
`default_nettype none
module sesf_prog #(
    parameter int unsigned MIN_CYC = sesf_pkg::PROG_MIN_CYC,
    parameter int unsigned MAX_CYC = sesf_pkg::PROG_MAX_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic timing_network_input_i,
    sesf_prog_if.prg prog
);
    logic rc_meta;
    logic rc_syn;
    logic [7:0] ent_addr [2];
    logic [7:0] ent_data [2];
    logic wp, rp, armed, push, pop, done, wr_en;
    logic [1:0] count;
    logic [7:0] wr_addr, wr_data;
    logic [sesf_pkg::PROG_CNT_W-1:0] tcnt;
    sesf_pkg::sesf_prog_state_t pstate;
    logic next_wp, next_rp, next_armed, next_wr_en;
    logic [1:0] next_count;
    logic [7:0] next_wr_addr, next_wr_data;
    logic [sesf_pkg::PROG_CNT_W-1:0] next_tcnt;
    sesf_pkg::sesf_prog_state_t next_pstate;

    assign prog.push_ready = (count != sesf_pkg::BUF_DEPTH);
    assign push = prog.push_valid & prog.push_ready;
    // cycle ends on the timing network once the least time is past
    assign done = (pstate == sesf_pkg::P_RUN) &&
        ((tcnt >= sesf_pkg::PROG_CNT_W'(MIN_CYC - 1) && rc_syn) ||
         tcnt >= sesf_pkg::PROG_CNT_W'(MAX_CYC - 1));
    assign pop = done;

    always_comb begin
        next_count = 2'(count + 2'(push) - 2'(pop));
        next_wp = wp ^ push;
        next_rp = rp ^ pop;
        next_armed = armed;
        if (prog.commit) begin
            next_armed = 1'b1;
        end else if (pop && next_count == 2'h0) begin
            next_armed = 1'b0;
        end
        next_pstate = pstate;
        next_tcnt = '0;
        unique case (pstate)
            sesf_pkg::P_IDLE: begin
                if (armed && count != 2'h0) begin
                    next_pstate = sesf_pkg::P_RUN;
                end
            end
            sesf_pkg::P_RUN: begin
                if (done) begin
                    next_pstate = sesf_pkg::P_IDLE;
                end else begin
                    next_tcnt = tcnt + 1'b1;
                end
            end
        endcase
        next_wr_en = pop;
        next_wr_addr = ent_addr[rp];
        next_wr_data = ent_data[rp];
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rc_meta <= 1'b0;
            rc_syn <= 1'b0;
            wp <= 1'b0;
            rp <= 1'b0;
            count <= 2'h0;
            armed <= 1'b0;
            pstate <= sesf_pkg::P_IDLE;
            tcnt <= '0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            rc_meta <= timing_network_input_i;
            rc_syn <= rc_meta;
            wp <= next_wp;
            rp <= next_rp;
            count <= next_count;
            armed <= next_armed;
            pstate <= next_pstate;
            tcnt <= next_tcnt;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            ent_addr[wp] <= prog.push_addr;
            ent_data[wp] <= prog.push_data;
        end
    end

    assign prog.busy = armed | (pstate == sesf_pkg::P_RUN);
    assign prog.wr_en = wr_en;
    assign prog.wr_addr = wr_addr;
    assign prog.wr_data = wr_data;
endmodule
`default_nettype wire

// ===== verilog/sesf_top.sv
/*
 * Two-wire serial slave front end of a 256 x 8 nonvolatile memory.
 * Assumes an external master drives SCL and an open-drain SDA wire.
 */
// Operation
// - Bus is idle while both data and clock lines are high.
// - SDA stays stable during SCL high; changes then are conditions.
// - SDA falling while SCL high is START.
// - Respond only when address chip-select bits match the strapped inputs.
// - Array holds 256 eight-bit words selected by word_address.
// - Erase/write cycle timed by the RC input, 20 to 100 ms.
// - Serial data accepted and returned at up to 100 kHz.
// - SCL and SDA filtered; pulses under the noise time are ignored.
// - Transmitted SDA held 300 ns past each falling SCL.
// - SDA rising while SCL high is STOP, ending the transfer.
// - Device acknowledges address, word_address and the first two written bytes.
// - At most two written bytes; programming begins only after STOP.
// - Read returns pointer byte, advancing only on master acknowledge.
`timescale 1ns/10ps
`default_nettype none
module sesf_top #(
    parameter int unsigned GLITCH_CYC = sesf_pkg::GLITCH_CYC,
    parameter int unsigned HOLD_CYC = sesf_pkg::SDA_HOLD_CYC,
    parameter int unsigned PROG_MIN_CYC = sesf_pkg::PROG_MIN_CYC,
    parameter int unsigned PROG_MAX_CYC = sesf_pkg::PROG_MAX_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] chip_select_inputs_i,
    input wire logic timing_network_input_i,
    output logic bus_idle_o,
    output logic program_busy_o
);
    sesf_line_if line ();
    sesf_prog_if prog ();

    sesf_filter #(
        .FILT_CYC(GLITCH_CYC)
    ) u_filter (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .cs_i(chip_select_inputs_i),
        .line(line.src)
    );

    sesf_prog #(
        .MIN_CYC(PROG_MIN_CYC),
        .MAX_CYC(PROG_MAX_CYC)
    ) u_prog (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .timing_network_input_i(timing_network_input_i),
        .prog(prog.prg)
    );

    logic [7:0] mem [sesf_pkg::MEM_WORDS];
    sesf_pkg::sesf_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic [7:0] tx, next_tx;
    logic [7:0] ptr, next_ptr;
    logic [1:0] wcount, next_wcount;
    logic [7:0] hold_cnt, next_hold_cnt;
    logic ack_phase, next_ack_phase;
    logic wpend, next_wpend;
    logic pend_oe, next_pend_oe;
    logic sda_oe, next_sda_oe;
    logic commit, next_commit;
    logic push_valid, next_push_valid;
    logic [7:0] push_addr, next_push_addr;
    logic [7:0] push_data, next_push_data;
    logic addr_match;

    // chip select and type compared, no answer while programming
    assign addr_match = (sh[7:4] == sesf_pkg::DEV_TYPE_CODE) &&
        (sh[3:1] == line.cs) && !prog.busy;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_tx = tx;
        next_ptr = ptr;
        next_wcount = wcount;
        next_ack_phase = ack_phase;
        next_wpend = wpend;
        next_pend_oe = pend_oe;
        next_sda_oe = sda_oe;
        next_hold_cnt = hold_cnt;
        next_commit = 1'b0;
        next_push_valid = 1'b0;
        next_push_addr = push_addr;
        next_push_data = push_data;
        if (hold_cnt != 8'h00) begin
            next_hold_cnt = hold_cnt - 8'h01;
            if (hold_cnt == 8'h01) begin
                next_sda_oe = pend_oe;
            end
        end
        if (line.start) begin
            next_state = sesf_pkg::S_ADDR;
            next_cnt = 4'h0;
            next_ack_phase = 1'b0;
            next_pend_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_hold_cnt = 8'h00;
        end else if (line.stop) begin
            next_state = sesf_pkg::S_IDLE;
            next_ack_phase = 1'b0;
            next_pend_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_hold_cnt = 8'h00;
            next_commit = wpend;
            next_wpend = 1'b0;
        end else if (line.scl_rise && !ack_phase) begin
            unique case (state)
                sesf_pkg::S_ADDR, sesf_pkg::S_WORD, sesf_pkg::S_WDATA: begin
                    if (cnt < sesf_pkg::BITS_PER_BYTE) begin
                        next_sh = {sh[6:0], line.sda};
                        next_cnt = cnt + 4'h1;
                    end
                end
                sesf_pkg::S_RDATA: begin
                    if (cnt < sesf_pkg::BITS_PER_BYTE) begin
                        next_tx = {tx[6:0], 1'b0};
                        next_cnt = cnt + 4'h1;
                    end else if (!line.sda) begin
                        next_ptr = ptr + 8'h01;
                        next_tx = mem[8'(ptr + 8'h01)];
                        next_cnt = 4'h0;
                    end else begin
                        next_state = sesf_pkg::S_IGNORE;
                    end
                end
                sesf_pkg::S_IDLE, sesf_pkg::S_IGNORE: begin
                end
                default: begin
                    next_state = sesf_pkg::S_IDLE;
                end
            endcase
        end else if (line.scl_fall) begin
            next_hold_cnt = 8'(HOLD_CYC);
            if (ack_phase) begin
                next_ack_phase = 1'b0;
                next_cnt = 4'h0;
                if (state == sesf_pkg::S_RDATA) begin
                    next_tx = mem[ptr];
                    next_pend_oe = ~mem[ptr][7];
                end else begin
                    next_pend_oe = 1'b0;
                end
            end else if (cnt == sesf_pkg::BITS_PER_BYTE) begin
                unique case (state)
                    sesf_pkg::S_ADDR: begin
                        if (addr_match) begin
                            next_ack_phase = 1'b1;
                            next_pend_oe = 1'b1;
                            // direction bit follows seven address bits
                            next_state = sh[0] ? sesf_pkg::S_RDATA : sesf_pkg::S_WORD;
                        end else begin
                            next_state = sesf_pkg::S_IGNORE;
                        end
                    end
                    sesf_pkg::S_WORD: begin
                        next_ptr = sh;
                        next_wcount = 2'h0;
                        next_ack_phase = 1'b1;
                        next_pend_oe = 1'b1;
                        next_state = sesf_pkg::S_WDATA;
                    end
                    sesf_pkg::S_WDATA: begin
                        if (wcount < sesf_pkg::MAX_WRITE_BYTES && prog.push_ready) begin
                            next_push_valid = 1'b1;
                            next_push_addr = ptr;
                            next_push_data = sh;
                            next_ptr = ptr + 8'h01;
                            next_wcount = wcount + 2'h1;
                            next_wpend = 1'b1;
                            next_ack_phase = 1'b1;
                            next_pend_oe = 1'b1;
                        end else begin
                            next_state = sesf_pkg::S_IGNORE;
                        end
                    end
                    sesf_pkg::S_RDATA: begin
                        next_pend_oe = 1'b0;
                    end
                    sesf_pkg::S_IDLE, sesf_pkg::S_IGNORE: begin
                    end
                    default: begin
                        next_state = sesf_pkg::S_IDLE;
                    end
                endcase
            end else if (state == sesf_pkg::S_RDATA) begin
                next_pend_oe = ~tx[7];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= sesf_pkg::S_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            wcount <= 2'h0;
            ack_phase <= 1'b0;
            wpend <= 1'b0;
            pend_oe <= 1'b0;
            sda_oe <= 1'b0;
            hold_cnt <= 8'h00;
            commit <= 1'b0;
            push_valid <= 1'b0;
            push_addr <= 8'h00;
            push_data <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            tx <= next_tx;
            ptr <= next_ptr;
            wcount <= next_wcount;
            ack_phase <= next_ack_phase;
            wpend <= next_wpend;
            pend_oe <= next_pend_oe;
            sda_oe <= next_sda_oe;
            hold_cnt <= next_hold_cnt;
            commit <= next_commit;
            push_valid <= next_push_valid;
            push_addr <= next_push_addr;
            push_data <= next_push_data;
        end
    end

    // array written only by the programming unit
    always_ff @(posedge core_clk_i) begin
        if (prog.wr_en) begin
            mem[prog.wr_addr] <= prog.wr_data;
        end
    end

    assign prog.push_valid = push_valid;
    assign prog.push_addr = push_addr;
    assign prog.push_data = push_data;
    assign prog.commit = commit;
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe;
    assign bus_idle_o = line.idle;
    assign program_busy_o = prog.busy;

    // cycles since the last filtered falling clock
    logic [7:0] fall_age, next_fall_age;

    always_comb begin
        next_fall_age = fall_age;
        if (line.scl_fall) begin
            next_fall_age = 8'h00;
        end else if (fall_age != 8'hff) begin
            next_fall_age = fall_age + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            fall_age <= 8'hff;
        end else begin
            fall_age <= next_fall_age;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    AST_START_TO_ADDR: assert property (line.start |=> state == sesf_pkg::S_ADDR)
        else $error("start did not enter address phase");
    AST_STOP_RELEASES: assert property (line.stop |=> (state == sesf_pkg::S_IDLE) && !sda_oe_o)
        else $error("stop did not end the transfer");
    AST_MISMATCH_IGNORED: assert property ((state == sesf_pkg::S_ADDR) && line.scl_fall &&
        !ack_phase && (cnt == 4'h8) && (sh[3:1] != line.cs) |=> state == sesf_pkg::S_IGNORE)
        else $error("foreign address was answered");
    AST_HOLD_AFTER_FALL: assert property (($changed(sda_oe_o) &&
        !$past(line.start || line.stop)) |-> (fall_age == 8'(HOLD_CYC)))
        else $error("data changed within hold after falling clock");
    AST_STABLE_CLOCK_HIGH: assert property (($changed(sda_oe_o) &&
        !$past(line.start || line.stop)) |-> !line.scl)
        else $error("data driven changed while clock high");
    AST_ACK_DRIVEN: assert property (ack_phase && line.scl_rise &&
        (state != sesf_pkg::S_RDATA) |-> sda_oe_o)
        else $error("acknowledge missing on ninth clock");
    AST_PTR_ON_ACK: assert property ((state == sesf_pkg::S_RDATA) && line.scl_rise &&
        !ack_phase && (cnt == 4'h8) |=> ptr == ($past(line.sda) ? $past(ptr) : 8'($past(ptr) + 8'h01)))
        else $error("pointer moved without master acknowledge");
    AST_TWO_BYTES_MAX: assert property (push_valid |-> (wcount != 2'h0) &&
        (wcount <= sesf_pkg::MAX_WRITE_BYTES))
        else $error("more than two bytes accepted");
    AST_COMMIT_AFTER_STOP: assert property (commit |-> $past(line.stop) && !prog.busy)
        else $error("programming started without stop");

    COV_READ_ACK: cover property ((state == sesf_pkg::S_RDATA) && line.scl_rise &&
        (cnt == 4'h8) && !line.sda);
    COV_TWO_BYTE_WRITE: cover property (push_valid && (wcount == 2'h2));
    COV_COMMIT: cover property (commit);
    COV_FOREIGN_ADDR: cover property ((state == sesf_pkg::S_ADDR) ##1 (state == sesf_pkg::S_IGNORE));
endmodule
`default_nettype wire

// ===== tb/sesf_master.sv
/*
 * Behavioural two-wire bus master, partner of the serial memory front end.
 * Assumes the bench resolves the open-drain data wire and feeds it back on line.
 */
`timescale 1ns/10ps
`default_nettype none
module sesf_master (
    output logic scl,
    output logic sda,
    input wire logic line
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start or repeated start, clock stands high when idle
    task automatic start();
        sda = 1'b1;
        #16 scl = 1'b1;
        #16 sda = 1'b0;
        #16 scl = 1'b0;
        #8;
    endtask
    task automatic stop();
        sda = 1'b0;
        #16 scl = 1'b1;
        #16 sda = 1'b1;
        #16;
    endtask
    // long low phase leaves room for the device's filtered turnaround
    task automatic bit_x(input logic b, output logic s);
        sda = b;
        #16 scl = 1'b1;
        #6 s = line;
        #2 scl = 1'b0;
        #8;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(~mack, s);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench of the serial memory slave front end.
 * Assumes a 250 MHz core clock and a 32 ns bus clock from the master model.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic tni = 1'b0;
    logic [2:0] cs = 3'h5;
    logic sda_o, sda_oe_o, bus_idle_o, program_busy_o, ack;
    logic [7:0] d;
    wire scl, sda_m;
    wire line = sda_m & ~(sda_oe_o & ~sda_o);
    int n_fail = 0;
    int cmp_count = 0;
    initial forever #2 core_clk_i = ~core_clk_i;
    sesf_top #(.GLITCH_CYC(1), .HOLD_CYC(1), .PROG_MIN_CYC(20), .PROG_MAX_CYC(100))
        sesf_top_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl),
        .sda_i(line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_inputs_i(cs),
        .timing_network_input_i(tni), .bus_idle_o(bus_idle_o),
        .program_busy_o(program_busy_o));
    sesf_master sesf_master_inst (.scl(scl), .sda(sda_m), .line(line));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_idle_prog();
        for (int i = 0; i < 300 && program_busy_o !== 1'b0; i++) begin
            @(posedge core_clk_i);
        end
        #1 chk("busy_end", 8'h00, {7'h0, program_busy_o});
    endtask
    task automatic t_reset();
        @(posedge core_clk_i);
        #1 chk("idle", 8'h01, {7'h0, bus_idle_o});
        chk("busy", 8'h00, {7'h0, program_busy_o});
        chk("oe", 8'h00, {7'h0, sda_oe_o});
        chk("sda_o", 8'h00, {7'h0, sda_o});
    endtask
    task automatic t_wrong_cs();
        sesf_master_inst.start();
        chk("idle_start", 8'h00, {7'h0, bus_idle_o});
        sesf_master_inst.wr_byte({4'ha, 3'h2, 1'b0}, ack);
        chk("ack_other_cs", 8'h00, {7'h0, ack});
        sesf_master_inst.stop();
        #20 chk("idle_stop", 8'h01, {7'h0, bus_idle_o});
    endtask
    task automatic t_write_two();
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b0}, ack);
        chk("ack_addr", 8'h01, {7'h0, ack});
        sesf_master_inst.wr_byte(8'hff, ack);
        chk("ack_word", 8'h01, {7'h0, ack});
        sesf_master_inst.wr_byte(8'h5a, ack);
        chk("ack_d0", 8'h01, {7'h0, ack});
        sesf_master_inst.wr_byte(8'ha5, ack);
        chk("ack_d1", 8'h01, {7'h0, ack});
        sesf_master_inst.wr_byte(8'h3c, ack);
        chk("ack_d2", 8'h00, {7'h0, ack});
        chk("busy_pre", 8'h00, {7'h0, program_busy_o});
        sesf_master_inst.stop();
        @(posedge core_clk_i);
        #1 tni = 1'b1;
        repeat (30) @(posedge core_clk_i);
        #1 chk("busy_two", 8'h01, {7'h0, program_busy_o});
        wait_idle_prog();
    endtask
    task automatic t_rc_slow();
        @(posedge core_clk_i);
        #1 tni = 1'b0;
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b0}, ack);
        sesf_master_inst.wr_byte(8'h10, ack);
        sesf_master_inst.wr_byte(8'h77, ack);
        sesf_master_inst.stop();
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b1}, ack);
        chk("ack_busy", 8'h00, {7'h0, ack});
        sesf_master_inst.stop();
        wait_idle_prog();
    endtask
    task automatic t_read();
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b0}, ack);
        sesf_master_inst.wr_byte(8'hff, ack);
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b1}, ack);
        chk("ack_rd", 8'h01, {7'h0, ack});
        sesf_master_inst.rd_byte(1'b1, d);
        chk("rd_ff", 8'h5a, d);
        sesf_master_inst.rd_byte(1'b0, d);
        chk("rd_wrap", 8'ha5, d);
        sesf_master_inst.stop();
        sesf_master_inst.start();
        sesf_master_inst.wr_byte({4'ha, cs, 1'b1}, ack);
        sesf_master_inst.rd_byte(1'b0, d);
        chk("rd_current", 8'ha5, d);
        sesf_master_inst.stop();
    endtask
    initial begin
        #50000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        t_reset();
        t_wrong_cs();
        t_write_two();
        t_rc_slow();
        t_read();
        test_done();
    end
endmodule
`default_nettype wire
